//--- core/cspin_addr.sv
`timescale 1ns/100ps
module cspin_addr #(
  parameter int AW = cspin_pkg::ADDR_W_BASE
) (
  input  wire logic          mclk_i,
  input  wire logic          nrst_i,
  input  wire logic          clr_i,
  input  wire logic          down_i,
  input  wire logic          step_i,
  output logic               strobe_o,
  output logic [AW-1:0]      addr_o,
  output logic               busy_o
);
  initial begin
    if (AW != cspin_pkg::ADDR_W_BASE && AW != cspin_pkg::ADDR_W_EXT) begin
      $error("address width must be 18 or 22");
    end
  end

  logic pend_r;

  // strobe rises, then address moves one cycle later
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      strobe_o <= 1'b0;
      pend_r   <= 1'b0;
      addr_o   <= '0;
    end else if (clr_i) begin
      strobe_o <= 1'b0;
      pend_r   <= 1'b0;
      addr_o   <= down_i ? '1 : '0;
    end else if (pend_r) begin
      pend_r   <= 1'b0;
      strobe_o <= 1'b0;
      addr_o   <= down_i ? addr_o - 1'b1 : addr_o + 1'b1;
    end else if (step_i) begin
      strobe_o <= 1'b1;
      pend_r   <= 1'b1;
    end
  end

  assign busy_o = pend_r;
endmodule

//--- core/cspin_pkg.sv
package cspin_pkg;

  localparam int CLK_MHZ = 200;
  // master-mode extra wait after init release, in microseconds
  localparam int WAIT_MIN_US = 30;
  localparam int WAIT_MAX_US = 300;
  localparam int WAIT_MIN_CYC = WAIT_MIN_US * CLK_MHZ;
  localparam int WAIT_MAX_CYC = WAIT_MAX_US * CLK_MHZ;
  // cycles between the strobe's rising edge and the address change
  localparam int STB_LEAD_CYC = 1;
  localparam int ADDR_W_BASE = 18;
  localparam int ADDR_W_EXT = 22;
  localparam int RDBK_BIT = 7;

  // mode pin code, bit order {two, one, zero}
  localparam logic [2:0] MODE_MSER = 3'h0;
  localparam logic [2:0] MODE_SPAR = 3'h1;
  localparam logic [2:0] MODE_APER = 3'h3;
  localparam logic [2:0] MODE_SPER = 3'h5;
  localparam logic [2:0] MODE_MPAR_UP = 3'h4;
  localparam logic [2:0] MODE_MPAR_DN = 3'h6;
  localparam logic [2:0] MODE_SSER = 3'h7;

  typedef enum logic [2:0] {
    CSPIN_MASTER_SERIAL,
    CSPIN_SLAVE_SERIAL,
    CSPIN_MASTER_PAR_UP,
    CSPIN_MASTER_PAR_DN,
    CSPIN_PERIPH_SYNC,
    CSPIN_PERIPH_ASYNC,
    CSPIN_SLAVE_PAR
  } cspin_mode_t;

  typedef struct packed {
    logic o;
    logic oe;
    logic pu;
  } cspin_pad_t;

  function automatic cspin_mode_t cspin_decode(input logic [2:0] m);
    unique case (m)
      MODE_MSER:    cspin_decode = CSPIN_MASTER_SERIAL;
      MODE_SPAR:    cspin_decode = CSPIN_SLAVE_PAR;
      MODE_APER:    cspin_decode = CSPIN_PERIPH_ASYNC;
      MODE_SPER:    cspin_decode = CSPIN_PERIPH_SYNC;
      MODE_MPAR_UP: cspin_decode = CSPIN_MASTER_PAR_UP;
      MODE_MPAR_DN: cspin_decode = CSPIN_MASTER_PAR_DN;
      default:      cspin_decode = CSPIN_SLAVE_SERIAL;
    endcase
  endfunction

  function automatic logic cspin_is_master(input cspin_mode_t md);
    cspin_is_master = (md == CSPIN_MASTER_SERIAL) ||
                      (md == CSPIN_MASTER_PAR_UP) ||
                      (md == CSPIN_MASTER_PAR_DN);
  endfunction

endpackage

//--- core/cspin_top.sv
`timescale 1ns/100ps
module cspin_top #(
  parameter int AW       = cspin_pkg::ADDR_W_BASE,
  parameter int WAIT_CYC = cspin_pkg::WAIT_MIN_CYC
) (
  input  wire logic               mclk_i,
  input  wire logic               nrst_i,
  // configuration core side
  input  wire logic               pwr_ok_i,
  input  wire logic               clear_busy_i,
  input  wire logic               cfg_err_i,
  input  wire logic               byte_busy_i,
  input  wire logic               addr_step_i,
  input  wire logic               io_active_i,
  input  wire logic               scan_used_i,
  output cspin_pkg::cspin_mode_t  mode_o,
  output logic                    mode_valid_o,
  output logic                    start_o,
  output logic                    step_ack_o,
  // init pin, open drain
  input  wire logic               init_n_i,
  output logic                    init_n_o,
  output logic                    init_n_oe_o,
  // ready/busy pin
  output cspin_pkg::cspin_pad_t   rdy_busy_o,
  input  wire logic               user_rdy_o_i,
  input  wire logic               user_rdy_oe_i,
  // async peripheral read
  input  wire logic               cs_i,
  input  wire logic               rd_i,
  output logic [7:0]              data_o,
  output logic                    data_oe_o,
  // master parallel address
  output logic                    addr_strobe_n_o,
  output logic [AW-1:0]           config_address_bus_o,
  output logic                    addr_oe_o,
  // mode pins
  input  wire logic               cfg_mode_sel_zero_i,
  input  wire logic               cfg_mode_sel_one_i,
  input  wire logic               cfg_mode_sel_two_i,
  output logic                    mode_pu_o,
  output logic                    user_mode_zero_o,
  output logic                    user_mode_two_o,
  input  wire logic               user_mode_one_i,
  input  wire logic               user_mode_one_oe_i,
  output logic                    cfg_mode_sel_one_o,
  output logic                    cfg_mode_sel_one_oe_o,
  // boundary scan pins
  input  wire logic               tdi_i,
  input  wire logic               tck_i,
  input  wire logic               tms_i,
  input  wire logic               scan_tdo_i,
  input  wire logic               user_tdo_i,
  input  wire logic               user_tdo_oe_i,
  output logic                    tdo_o,
  output logic                    tdo_oe_o,
  output logic                    scan_tdi_o,
  output logic                    scan_tck_o,
  output logic                    scan_tms_o,
  output logic                    scan_active_o,
  output logic                    user_tdi_o,
  output logic                    user_tck_o,
  output logic                    user_tms_o,
  // configuring indicators
  output logic                    high_while_configuring_o,
  output logic                    high_while_configuring_oe_o,
  output logic                    low_while_configuring_o,
  output logic                    low_while_configuring_oe_o
);
  typedef enum logic [2:0] {
    CSPIN_ST_CLEAR,
    CSPIN_ST_WAIT,
    CSPIN_ST_MWAIT,
    CSPIN_ST_LOAD,
    CSPIN_ST_USER
  } cspin_st_t;

  cspin_st_t              st_r;
  cspin_st_t              st_nxt;
  cspin_pkg::cspin_mode_t mode_r;
  logic                   mode_valid_r;
  logic                   init_low_r;
  logic                   wait_busy;
  logic                   wait_done;
  logic                   wait_start;
  logic                   is_master;
  logic                   is_periph;
  logic                   configuring;
  logic                   addr_busy;
  logic                   addr_clr;
  logic                   addr_step;

  assign is_master = cspin_pkg::cspin_is_master(
                       cspin_pkg::cspin_decode({cfg_mode_sel_two_i,
                                                cfg_mode_sel_one_i,
                                                cfg_mode_sel_zero_i}));
  assign is_periph = (mode_r == cspin_pkg::CSPIN_PERIPH_SYNC) ||
                     (mode_r == cspin_pkg::CSPIN_PERIPH_ASYNC);
  assign configuring = (st_r != CSPIN_ST_USER);

  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      CSPIN_ST_CLEAR: begin
        if (pwr_ok_i && !clear_busy_i) begin
          st_nxt = CSPIN_ST_WAIT;
        end
      end
      CSPIN_ST_WAIT: begin
        if (clear_busy_i) begin
          st_nxt = CSPIN_ST_CLEAR;
        end else if (init_n_i) begin
          st_nxt = is_master ? CSPIN_ST_MWAIT : CSPIN_ST_LOAD;
        end
      end
      CSPIN_ST_MWAIT: begin
        if (wait_done) begin
          st_nxt = CSPIN_ST_LOAD;
        end
      end
      CSPIN_ST_LOAD: begin
        if (io_active_i) begin
          st_nxt = CSPIN_ST_USER;
        end
      end
      CSPIN_ST_USER: begin
        if (clear_busy_i) begin
          st_nxt = CSPIN_ST_CLEAR;
        end
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_r <= CSPIN_ST_CLEAR;
    end else begin
      st_r <= st_nxt;
    end
  end

  // mode caught on the init release edge
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mode_r       <= cspin_pkg::CSPIN_SLAVE_SERIAL;
      mode_valid_r <= 1'b0;
    end else if (st_r == CSPIN_ST_WAIT && init_n_i && !clear_busy_i) begin
      mode_r       <= cspin_pkg::cspin_decode({cfg_mode_sel_two_i,
                                                cfg_mode_sel_one_i,
                                                cfg_mode_sel_zero_i});
      mode_valid_r <= 1'b1;
    end else if (st_r == CSPIN_ST_CLEAR) begin
      mode_valid_r <= 1'b0;
    end
  end

  assign mode_o       = mode_r;
  assign mode_valid_o = mode_valid_r;
  assign start_o      = (st_r == CSPIN_ST_LOAD);
  assign wait_start   = (st_r == CSPIN_ST_WAIT) && (st_nxt == CSPIN_ST_MWAIT);

  cspin_wait #(
    .WAIT_CYC (WAIT_CYC)
  ) u_wait (
    .mclk_i  (mclk_i),
    .nrst_i  (nrst_i),
    .start_i (wait_start),
    .busy_o  (wait_busy),
    .done_o  (wait_done)
  );

  // init low during clear, or on data error while loading
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      init_low_r <= 1'b1;
    end else begin
      init_low_r <= (st_nxt == CSPIN_ST_CLEAR) ||
                    (st_nxt == CSPIN_ST_LOAD && cfg_err_i);
    end
  end

  assign init_n_o    = 1'b0;
  assign init_n_oe_o = init_low_r;

  // ready/busy pad
  always_comb begin
    rdy_busy_o = '0;
    if (st_r == CSPIN_ST_USER) begin
      rdy_busy_o.o  = user_rdy_o_i;
      rdy_busy_o.oe = user_rdy_oe_i;
    end else if (st_r == CSPIN_ST_CLEAR || st_r == CSPIN_ST_WAIT) begin
      rdy_busy_o.pu = 1'b1;
    end else begin
      rdy_busy_o.o  = !byte_busy_i;
      rdy_busy_o.oe = 1'b1;
    end
  end

  // status readback on data bit seven
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      data_o    <= 8'h00;
      data_oe_o <= 1'b0;
    end else begin
      data_oe_o <= (st_r == CSPIN_ST_LOAD) &&
                   (mode_r == cspin_pkg::CSPIN_PERIPH_ASYNC) &&
                   cs_i && rd_i;
      data_o    <= 8'h00;
      data_o[cspin_pkg::RDBK_BIT] <= !byte_busy_i;
    end
  end

  assign addr_clr = (st_r != CSPIN_ST_LOAD);
  // steps refused outside load and in peripheral modes
  assign addr_step = addr_step_i && !addr_clr && !is_periph;

  cspin_addr #(
    .AW (AW)
  ) u_addr (
    .mclk_i   (mclk_i),
    .nrst_i   (nrst_i),
    .clr_i    (addr_clr),
    .down_i   (mode_r == cspin_pkg::CSPIN_MASTER_PAR_DN),
    .step_i   (addr_step),
    .strobe_o (addr_strobe_n_o),
    .addr_o   (config_address_bus_o),
    .busy_o   (addr_busy)
  );

  assign step_ack_o = addr_step && !addr_busy;
  assign addr_oe_o  = (st_r == CSPIN_ST_LOAD) &&
                      (mode_r == cspin_pkg::CSPIN_MASTER_PAR_UP ||
                       mode_r == cspin_pkg::CSPIN_MASTER_PAR_DN);

  // mode pins
  assign mode_pu_o             = configuring;
  assign user_mode_zero_o      = configuring ? 1'b0 : cfg_mode_sel_zero_i;
  assign user_mode_two_o       = configuring ? 1'b0 : cfg_mode_sel_two_i;
  assign cfg_mode_sel_one_o    = user_mode_one_i;
  assign cfg_mode_sel_one_oe_o = !configuring && user_mode_one_oe_i;

  // boundary scan routing
  assign scan_active_o = configuring || scan_used_i;
  assign scan_tdi_o    = scan_active_o ? tdi_i : 1'b0;
  assign scan_tck_o    = scan_active_o ? tck_i : 1'b0;
  assign scan_tms_o    = scan_active_o ? tms_i : 1'b0;
  assign user_tdi_o    = scan_active_o ? 1'b0 : tdi_i;
  assign user_tck_o    = scan_active_o ? 1'b0 : tck_i;
  assign user_tms_o    = scan_active_o ? 1'b0 : tms_i;

  always_comb begin
    if (scan_active_o) begin
      tdo_o    = scan_tdo_i;
      tdo_oe_o = 1'b1;
    end else begin
      tdo_o    = user_tdo_i;
      tdo_oe_o = user_tdo_oe_i;
    end
  end

  // configuring indicators
  assign high_while_configuring_o    = configuring;
  assign high_while_configuring_oe_o = configuring;
  assign low_while_configuring_o     = !configuring;
  assign low_while_configuring_oe_o  = configuring;

  logic unused_w;
  assign unused_w = wait_busy;
endmodule

//--- core/cspin_wait.sv
`timescale 1ns/100ps
module cspin_wait #(
  parameter int WAIT_CYC = cspin_pkg::WAIT_MIN_CYC
) (
  input  wire logic mclk_i,
  input  wire logic nrst_i,
  input  wire logic start_i,
  output logic      busy_o,
  output logic      done_o
);
  localparam int CW = $clog2(WAIT_CYC + 1);

  initial begin
    if (WAIT_CYC < cspin_pkg::WAIT_MIN_CYC ||
        WAIT_CYC > cspin_pkg::WAIT_MAX_CYC) begin
      $error("wait count out of range");
    end
  end

  logic [CW-1:0] cnt_r;

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_r  <= '0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end else if (start_i) begin
      cnt_r  <= CW'(WAIT_CYC - 1);
      busy_o <= 1'b1;
      done_o <= 1'b0;
    end else if (busy_o) begin
      if (cnt_r == '0) begin
        busy_o <= 1'b0;
        done_o <= 1'b1;
      end else begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end
endmodule

//--- tb/cspin_host.sv
`timescale 1ns/100ps
module cspin_host (
  input  wire logic             mclk_i,
  input  wire logic             nrst_i,
  input  wire logic [2:0]       strap_i,
  input  wire logic             open_i,
  input  wire logic             pu_i,
  input  wire logic             init_n_oe_i,
  input  wire logic             rd_go_i,
  input  cspin_pkg::cspin_pad_t rdy_i,
  output logic [2:0]            pins_o,
  output logic                  init_n_o,
  output logic                  cs_o,
  output logic                  rd_o,
  output logic                  may_wr_o
);
  logic [2:0] last_r;
  // open pins float to the pull-up, else wander
  assign pins_o = !open_i ? strap_i : (pu_i ? 3'h7 : ~last_r);
  assign init_n_o = !init_n_oe_i;
  assign may_wr_o = rdy_i.oe && rdy_i.o;
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      last_r <= 3'h0;
      cs_o <= 1'b0;
      rd_o <= 1'b0;
    end else begin
      last_r <= pins_o;
      cs_o <= rd_go_i;
      rd_o <= rd_go_i;
    end
  end
endmodule

//--- tb/cspin_monitor.sv
`timescale 1ns/100ps
module cspin_monitor #(
  parameter int AW = cspin_pkg::ADDR_W_BASE
) (
  input logic                   mclk_i,
  input logic                   nrst_i,
  input logic                   pwr_ok_i,
  input logic                   clear_busy_i,
  input logic                   byte_busy_i,
  input logic                   cs_i,
  input logic                   rd_i,
  input logic                   scan_tdo_i,
  input logic                   scan_used_i,
  input cspin_pkg::cspin_mode_t mode_o,
  input logic                   mode_valid_o,
  input logic                   start_o,
  input logic                   step_ack_o,
  input logic                   init_n_oe_o,
  input cspin_pkg::cspin_pad_t  rdy_busy_o,
  input logic [7:0]             data_o,
  input logic                   data_oe_o,
  input logic                   addr_strobe_n_o,
  input logic [AW-1:0]          config_address_bus_o,
  input logic                   mode_pu_o,
  input logic                   tdo_o,
  input logic                   scan_active_o,
  input logic                   high_while_configuring_o,
  input logic                   high_while_configuring_oe_o,
  input logic                   low_while_configuring_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!nrst_i);
  sequence s_take;
    step_ack_o;
  endsequence
  sequence s_pulse;
    addr_strobe_n_o ##1 !addr_strobe_n_o;
  endsequence
  a_strobe_pulse: assert property (s_take |=> s_pulse)
    else $error("no strobe pulse");
  a_addr_strobe: assert property (
    $past(start_o) && $changed(config_address_bus_o) |->
    $fell(addr_strobe_n_o))
    else $error("address moved without strobe");
  a_readback_bit: assert property (
    cs_i && rd_i && start_o && mode_o == cspin_pkg::CSPIN_PERIPH_ASYNC
    |=> data_oe_o && data_o[7] == !$past(byte_busy_i))
    else $error("bad readback bit");
  a_rdy_weak: assert property (
    !mode_valid_o |-> rdy_busy_o.pu && !rdy_busy_o.oe)
    else $error("ready pin driven early");
  a_init_release: assert property (
    $fell(init_n_oe_o) |-> $past(pwr_ok_i) && !$past(clear_busy_i))
    else $error("init released early");
  a_mode_pullup: assert property (
    high_while_configuring_oe_o |-> mode_pu_o)
    else $error("mode pull-ups off");
  a_cfg_flags: assert property (
    high_while_configuring_oe_o |->
    high_while_configuring_o && !low_while_configuring_o)
    else $error("indicator levels");
  a_tdo_scan: assert property (
    scan_active_o |-> tdo_o == scan_tdo_i)
    else $error("tdo not scan output");
  a_scan_off: assert property (
    !high_while_configuring_oe_o && !scan_used_i |-> !scan_active_o)
    else $error("scan left on");
endmodule

bind cspin_top cspin_monitor #(.AW(AW)) i_mon (.*);

//--- tb/cspin_top_tb.sv
`timescale 1ns/100ps
module cspin_top_tb;
  localparam int AW = cspin_pkg::ADDR_W_EXT;
  localparam int WC = cspin_pkg::WAIT_MIN_CYC;
  logic mclk_i, nrst_i, pwr_ok_i, clear_busy_i, cfg_err_i, byte_busy_i;
  logic addr_step_i, io_active_i, scan_used_i, init_n_i, cs_i, rd_i;
  logic user_rdy_o_i, user_rdy_oe_i, user_mode_one_i, user_mode_one_oe_i;
  logic tdi_i, tck_i, tms_i, scan_tdo_i, user_tdo_i, user_tdo_oe_i;
  logic cfg_mode_sel_zero_i, cfg_mode_sel_one_i, cfg_mode_sel_two_i;
  cspin_pkg::cspin_mode_t mode_o;
  cspin_pkg::cspin_pad_t  rdy_busy_o;
  logic mode_valid_o, start_o, step_ack_o, init_n_o, init_n_oe_o;
  logic [7:0] data_o;
  logic data_oe_o, addr_strobe_n_o, addr_oe_o, mode_pu_o;
  logic [AW-1:0] config_address_bus_o;
  logic user_mode_zero_o, user_mode_two_o, cfg_mode_sel_one_o;
  logic cfg_mode_sel_one_oe_o, tdo_o, tdo_oe_o, scan_tdi_o, scan_tck_o;
  logic scan_tms_o, scan_active_o, user_tdi_o, user_tck_o, user_tms_o;
  logic high_while_configuring_o, high_while_configuring_oe_o;
  logic low_while_configuring_o, low_while_configuring_oe_o;
  logic rd_go, open_pins, may_wr;
  logic [2:0] strap, mpins;
  logic [31:0] rnd;
  int n_errors, num_checks;

  cspin_top #(.AW(AW)) i_dut (.*);
  cspin_host i_host (.mclk_i, .nrst_i, .strap_i(strap), .open_i(open_pins),
    .pu_i(mode_pu_o), .init_n_oe_i(init_n_oe_o), .rd_go_i(rd_go),
    .rdy_i(rdy_busy_o), .pins_o(mpins), .init_n_o(init_n_i), .cs_o(cs_i),
    .rd_o(rd_i), .may_wr_o(may_wr));

  assign {cfg_mode_sel_two_i, cfg_mode_sel_one_i, cfg_mode_sel_zero_i} = mpins;
  assign {user_rdy_o_i, user_rdy_oe_i, user_mode_one_i, user_mode_one_oe_i,
          tdi_i, tck_i, tms_i, scan_tdo_i, user_tdo_i, user_tdo_oe_i} = rnd[9:0];

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic cspin_pkg::cspin_mode_t exp_mode(input logic [2:0] c);
    case (c)
      3'h0: exp_mode = cspin_pkg::CSPIN_MASTER_SERIAL;
      3'h1: exp_mode = cspin_pkg::CSPIN_SLAVE_PAR;
      3'h3: exp_mode = cspin_pkg::CSPIN_PERIPH_ASYNC;
      3'h4: exp_mode = cspin_pkg::CSPIN_MASTER_PAR_UP;
      3'h5: exp_mode = cspin_pkg::CSPIN_PERIPH_SYNC;
      3'h6: exp_mode = cspin_pkg::CSPIN_MASTER_PAR_DN;
      default: exp_mode = cspin_pkg::CSPIN_SLAVE_SERIAL;
    endcase
  endfunction

  task automatic chk_bit(input logic got, input logic exp, input string m);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp,
                          input string m);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic configure(input logic [2:0] c, input logic op);
    int n;
    logic [2:0] e;
    e = op ? 3'h7 : c;
    @(posedge mclk_i) nrst_i <= 1'b0;
    pwr_ok_i <= 1'b0;
    io_active_i <= 1'b0;
    strap <= c;
    open_pins <= op;
    scan_used_i <= c[0];
    repeat (4) @(posedge mclk_i);
    nrst_i <= 1'b1;
    repeat (3) @(negedge mclk_i);
    chk_bit(init_n_oe_o, 1'b1, "init");
    chk_bit(rdy_busy_o.pu & ~rdy_busy_o.oe, 1'b1, "ready weak");
    chk_bit(high_while_configuring_o, 1'b1, "high flag");
    chk_bit(low_while_configuring_o, 1'b0, "low flag");
    chk_bit(mode_pu_o, 1'b1, "mode pull-ups");
    @(posedge mclk_i) pwr_ok_i <= 1'b1;
    n = 0;
    while (mode_valid_o !== 1'b1 && n < 20) begin
      @(negedge mclk_i);
      n++;
    end
    chk_bit(mode_valid_o, 1'b1, "mode valid");
    chk_word(32'(mode_o), 32'(exp_mode(e)), "mode");
    n = 0;
    while (start_o !== 1'b1 && n < 70000) begin
      @(negedge mclk_i);
      n++;
    end
    if (e == 3'h0 || e == 3'h4 || e == 3'h6)
      chk_bit(n >= WC && n <= WC + 4, 1'b1, "master wait");
    else
      chk_bit(n <= 3, 1'b1, "no wait");
  endtask

  task automatic addr_test(input logic dn);
    int n;
    logic [AW-1:0] a0;
    repeat (12) begin
      @(posedge mclk_i) addr_step_i <= 1'b1;
      n = 0;
      do begin
        @(negedge mclk_i);
        n++;
      end while (step_ack_o !== 1'b1 && n < 20);
      chk_bit(step_ack_o, 1'b1, "step taken");
      chk_bit(addr_oe_o, 1'b1, "address drive");
      a0 = config_address_bus_o;
      @(posedge mclk_i) addr_step_i <= 1'b0;
      @(negedge mclk_i);
      chk_bit(addr_strobe_n_o, 1'b1, "strobe");
      chk_word(32'(config_address_bus_o), 32'(a0), "early address");
      a0 = dn ? a0 - 1'b1 : a0 + 1'b1;
      @(negedge mclk_i);
      chk_bit(addr_strobe_n_o, 1'b0, "strobe end");
      chk_word(32'(config_address_bus_o), 32'(a0), "address");
      repeat (rnd[2:0]) @(posedge mclk_i);
    end
  endtask

  task automatic periph_test(input logic asy);
    repeat (10) begin
      @(posedge mclk_i) rd_go <= 1'b1;
      byte_busy_i <= rnd[3];
      @(posedge mclk_i) rd_go <= 1'b0;
      @(posedge mclk_i);
      @(negedge mclk_i);
      chk_bit(may_wr, ~byte_busy_i, "ready pin");
      if (asy) begin
        chk_bit(data_oe_o, 1'b1, "readback drive");
        chk_bit(data_o[7], ~byte_busy_i, "readback bit");
      end
    end
  endtask

  task automatic user_phase;
    @(posedge mclk_i) io_active_i <= 1'b1;
    repeat (3) @(negedge mclk_i);
    chk_bit(high_while_configuring_oe_o, 1'b0, "high flag oe");
    chk_bit(low_while_configuring_oe_o, 1'b0, "low flag oe");
    chk_bit(rdy_busy_o.o, user_rdy_o_i, "ready user");
    chk_bit(rdy_busy_o.oe, user_rdy_oe_i, "ready user oe");
    chk_bit(user_mode_zero_o, cfg_mode_sel_zero_i, "mode zero");
    chk_bit(user_mode_two_o, cfg_mode_sel_two_i, "mode two");
    chk_bit(cfg_mode_sel_one_oe_o, user_mode_one_oe_i, "mode one");
    chk_bit(scan_active_o, scan_used_i, "scan state");
    chk_bit(tdo_o, scan_used_i ? scan_tdo_i : user_tdo_i, "tdo");
    chk_bit(scan_tdi_o, scan_used_i & tdi_i, "scan input");
    chk_bit(user_tdi_o, ~scan_used_i & tdi_i, "user input");
    chk_bit(tdo_oe_o, scan_used_i | user_tdo_oe_i, "tdo oe");
    chk_bit(cfg_mode_sel_one_o, user_mode_one_i, "mode one out");
    @(posedge mclk_i) io_active_i <= 1'b0;
    clear_busy_i <= 1'b1;
    repeat (2) @(negedge mclk_i);
    chk_bit(init_n_oe_o, 1'b1, "init in clear");
    @(posedge mclk_i) clear_busy_i <= 1'b0;
  endtask

  always @(posedge mclk_i) rnd <= lfsr(rnd);

  initial begin
    mclk_i = 1'b0;
    forever #2.5 mclk_i = ~mclk_i;
  end

  initial begin
    #(60000 * 5);
    n_errors++;
    $display("wrong value at %0t: watchdog", $time);
    final_report;
  end

  initial begin
    rnd = 32'hF3BD6D82;
    {nrst_i, pwr_ok_i, clear_busy_i, cfg_err_i, byte_busy_i} = 5'h00;
    {addr_step_i, io_active_i, scan_used_i, rd_go, open_pins} = 5'h00;
    strap = 3'h0;
    n_errors = 0;
    num_checks = 0;
    for (int c = 0; c < 8; c++) begin
      configure(3'(c), 1'b0);
      if (c == 4 || c == 6)
        addr_test(c == 6);
      if (c == 3 || c == 5)
        periph_test(c == 3);
      user_phase;
      $display("test mode %0d done", c);
    end
    configure(3'h0, 1'b1);
    @(posedge mclk_i) cfg_err_i <= 1'b1;
    repeat (2) @(negedge mclk_i);
    chk_bit(init_n_oe_o, 1'b1, "error on init");
    $display("test open pins done");
    final_report;
  end
endmodule
